// file: hdl/tim_pwm_top.sv
// four channel timer with buffered pwm pairs, capture and flags
`timescale 1ns/1ps
`default_nettype none
module tim_pwm_top
	import tim_pkg::*;
(
	input  wire logic                        mclk_i,                 // 40 MHz clock
	input  wire logic                        rstn_i,                 // sync reset, low
	// counter control
	input  wire logic                        counter_stop_i,         // halt counting
	input  wire logic                        counter_reset_i,        // clear counter pulse
	input  wire logic [2:0]                  prescaler_select_i,     // clock source
	input  wire logic [CNT_W-1:0]            period_modulo_i,        // period value
	input  wire logic                        overflow_irq_enable_i,  // overflow irq gate
	input  wire logic                        ovf_status_read_i,      // timer status read
	input  wire logic                        ovf_clear_write_i,      // write zero to flag
	// channel control
	input  wire logic                        pair01_link_i,          // link 0 and 1
	input  wire logic                        pair23_link_i,          // link 2 and 3
	input  wire logic [NUM_CH-1:0]           unbuffered_mode_sel_i,  // compare mode
	input  wire logic [NUM_CH-1:0]           toggle_on_overflow_i,   // toggle at wrap
	input  wire logic [NUM_CH-1:0][1:0]      compare_action_sel_i,   // action / edge
	input  wire logic [NUM_CH-1:0]           max_duty_force_i,       // full duty
	input  wire logic [NUM_CH-1:0]           channel_irq_enable_i,   // channel irq gate
	input  wire logic [NUM_CH-1:0]           compare_write_i,        // value write pulse
	input  wire logic [NUM_CH-1:0][CNT_W-1:0] channel_compare_value_i, // write data
	input  wire logic [NUM_CH-1:0]           chan_status_read_i,     // channel status read
	input  wire logic [NUM_CH-1:0]           chan_clear_write_i,     // write zero to flag
	// system state
	input  wire logic                        wait_mode_i,            // cpu waiting
	input  wire logic                        break_i,                // break state
	input  wire logic                        break_clear_enable_i,   // clear allowed
	input  wire logic                        port_direction_bit_i,   // ext pin direction
	input  wire logic                        external_timer_clock_i, // external clock
	input  wire logic [NUM_CH-1:0]           channel_pin_i,          // channel pins in
	// outputs
	output logic [NUM_CH-1:0]                channel_pin_o,          // channel pins out
	output logic [NUM_CH-1:0]                channel_pin_oe_o,       // timer drives pin
	output logic                             ext_clock_pin_oe_o,     // ext pin drive
	output logic [CNT_W-1:0]                 counter_o,              // counter value
	output logic [NUM_CH-1:0][CNT_W-1:0]     channel_value_o,        // channel registers
	output logic [1:0]                       pair_active_odd_o,      // odd set active
	output logic                             overflow_flag_o,        // overflow flag
	output logic [NUM_CH-1:0]                channel_event_flag_o,   // channel flags
	output logic                             irq_o                   // request and wake
);
	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0]             count;
		logic [NUM_CH-1:0][CNT_W-1:0] value;
		logic [NUM_CH-1:0]            out;
		logic [NUM_CH-1:0]            oe;
		logic [NUM_CH-1:0]            pin_prev;
		logic [NUM_PAIRS-1:0]         active_odd;
		logic [NUM_PAIRS-1:0]         last_odd;
		logic                         ext_oe;
		logic                         irq;
	} top_t;

	top_t s;
	top_t next_s;

	timer_bus_if bus ();

	logic                 run;
	logic                 wrap;
	logic [NUM_CH-1:0]    wr;
	logic [NUM_CH-1:0]    rd;
	logic [NUM_CH-1:0]    clr;
	logic                 ovf_rd;
	logic                 ovf_clr;
	logic                 cnt_clear;
	logic [NUM_CH-1:0]    event_pulse;
	logic [NUM_CH-1:0]    flag;
	logic                 ovf_flag;
	logic [NUM_PAIRS-1:0] link;

	// --------------------------------------------------------------
	// decode helpers
	// --------------------------------------------------------------
	// even channel leading a linked pair
	function automatic logic is_master(input int unsigned ch,
			input logic [NUM_PAIRS-1:0] lk);
		return ((ch % 2) == 0) && lk[ch/2];
	endfunction

	// odd channel swallowed by a linked pair
	function automatic logic is_slave(input int unsigned ch,
			input logic [NUM_PAIRS-1:0] lk);
		return ((ch % 2) == 1) && lk[ch/2];
	endfunction

	// --------------------------------------------------------------
	// access gating and counter control
	// --------------------------------------------------------------
	// cpu strobes are dropped while waiting
	assign wr      = compare_write_i & {NUM_CH{~wait_mode_i}};
	assign rd      = chan_status_read_i & {NUM_CH{~wait_mode_i}};
	assign clr     = chan_clear_write_i & {NUM_CH{~wait_mode_i}};
	assign ovf_rd  = ovf_status_read_i & ~wait_mode_i;
	assign ovf_clr = ovf_clear_write_i & ~wait_mode_i;
	assign cnt_clear = counter_reset_i & ~wait_mode_i;

	// wait mode keeps counting, break halts it
	assign run = ~counter_stop_i & ~break_i;

	// protected break blocks status clearing
	assign bus.access_ok = ~break_i | break_clear_enable_i;

	// overflow when the counter steps off the modulo value
	assign wrap = bus.tick & run & ~cnt_clear
		& (s.count == period_modulo_i);

	// pair link bits
	assign link = {pair23_link_i, pair01_link_i};

	// --------------------------------------------------------------
	// submodules
	// --------------------------------------------------------------
	tim_prescaler u_presc (
		.mclk_i                 (mclk_i),
		.rstn_i                 (rstn_i),
		.bus                    (bus.presc),
		.run_i                  (run),
		.clear_i                (cnt_clear),
		.prescaler_select_i     (prescaler_select_i),
		.external_timer_clock_i (external_timer_clock_i)
	);

	tim_flag u_ovf_flag (
		.mclk_i  (mclk_i),
		.rstn_i  (rstn_i),
		.bus     (bus.flag),
		.set_i   (wrap),
		.read_i  (ovf_rd),
		.clear_i (ovf_clr),
		.flag_o  (ovf_flag)
	);

	// one sticky flag per channel
	generate
		for (genvar g = 0; g < NUM_CH; g++) begin : g_flag
			tim_flag u_chan_flag (
				.mclk_i  (mclk_i),
				.rstn_i  (rstn_i),
				.bus     (bus.flag),
				.set_i   (event_pulse[g]),
				.read_i  (rd[g]),
				.clear_i (clr[g]),
				.flag_o  (flag[g])
			);
		end
	endgenerate

	// --------------------------------------------------------------
	// channel, pair and counter next state
	// --------------------------------------------------------------
	always_comb begin
		logic              is_out;
		logic              active;
		logic              match;
		logic              capture;
		logic [1:0]        act;
		logic [CNT_W-1:0]  cmp;
		logic [NUM_PAIRS-1:0] last;
		next_s = s;
		event_pulse = '0;
		is_out = 1'b0;
		active = 1'b0;
		match = 1'b0;
		capture = 1'b0;
		act = ACT_OFF;
		cmp = COUNT_RESET;
		last = s.last_odd;

		// free running counter with modulo wrap
		if (cnt_clear) begin
			next_s.count = COUNT_RESET;
		end else if (wrap) begin
			next_s.count = COUNT_RESET;
		end else if (bus.tick && run) begin
			next_s.count = s.count + COUNT_ONE;
		end

		// register set selection for linked pairs
		for (int unsigned p = 0; p < NUM_PAIRS; p++) begin
			if (!link[p]) begin
				last[p] = 1'b0;
				next_s.active_odd[p] = 1'b0; // even set controls first
			end else begin
				if (wr[2*p]) begin
					last[p] = 1'b0;
				end
				if (wr[2*p+1]) begin
					last[p] = 1'b1;
				end
				if (wrap) begin
					next_s.active_odd[p] = last[p];
				end
			end
		end
		next_s.last_odd = last;

		// per channel compare, capture and pin logic
		for (int unsigned c = 0; c < NUM_CH; c++) begin
			act = compare_action_sel_i[c];
			next_s.pin_prev[c] = channel_pin_i[c];
			// link wins over the unbuffered select
			is_out = is_master(c, link) | unbuffered_mode_sel_i[c];
			active = ~is_slave(c, link) & (act != ACT_OFF);
			cmp = s.value[c];
			if (is_master(c, link) && s.active_odd[c/2]) begin
				cmp = s.value[c | 1];
			end
			match = active & is_out & bus.tick & run
				& (s.count == cmp);
			capture = 1'b0;
			if (active && !is_out) begin
				case (act)
					ACT_TOGGLE: capture = channel_pin_i[c] & ~s.pin_prev[c];
					ACT_CLEAR:  capture = ~channel_pin_i[c] & s.pin_prev[c];
					ACT_SET:    capture = channel_pin_i[c] ^ s.pin_prev[c];
					default:    capture = 1'b0;
				endcase
			end
			event_pulse[c] = match | capture;

			// channel register: capture beats a cpu write
			if (capture) begin
				next_s.value[c] = s.count;
			end else if (wr[c]) begin
				next_s.value[c] = channel_compare_value_i[c];
			end

			// output level
			next_s.oe[c] = active & is_out;
			if (is_slave(c, link)) begin
				next_s.out[c] = 1'b0;
			end else if (act == ACT_OFF) begin
				next_s.out[c] = ~unbuffered_mode_sel_i[c]; // initial level
			end else if (is_out) begin
				if (wrap && max_duty_force_i[c]) begin
					next_s.out[c] = (act == ACT_CLEAR);
				end else if (wrap && toggle_on_overflow_i[c]) begin
					next_s.out[c] = ~s.out[c];
				end else if (match && !max_duty_force_i[c]) begin
					case (act)
						ACT_TOGGLE: next_s.out[c] = ~s.out[c];
						ACT_CLEAR:  next_s.out[c] = 1'b0;
						ACT_SET:    next_s.out[c] = 1'b1;
						default:    next_s.out[c] = s.out[c];
					endcase
				end
			end
		end

		// external clock pin is input while selected
		next_s.ext_oe = port_direction_bit_i
			& (prescaler_select_i != PS_EXT_CLOCK);

		// one request line, also the wake source
		next_s.irq = (ovf_flag & overflow_irq_enable_i)
			| |(flag & channel_irq_enable_i);
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	// all straight from flip-flops
	assign channel_pin_o        = s.out;
	assign channel_pin_oe_o     = s.oe;
	assign ext_clock_pin_oe_o   = s.ext_oe;
	assign counter_o            = s.count;
	assign channel_value_o      = s.value;
	assign pair_active_odd_o    = s.active_odd;
	assign overflow_flag_o      = ovf_flag;
	assign channel_event_flag_o = flag;
	assign irq_o                = s.irq;
endmodule
`default_nettype wire

// file: hdl/tim_pkg.sv
// constants and the divider mask function shared by the buffered pwm timer block
// Summary of operation
// - pair01_link joins channels 0/1 onto pin 0
// - pair23_link joins channels 2/3 onto pin 2
// - odd register write takes over next period
// - each overflow selects last written register set
// - mode and compare action encodings fixed
// - pair link overrides unbuffered mode select
// - no overflow toggle gives zero duty
// - max duty with no toggle gives full duty
// - overflow flag at wrap, gated interrupt
// - channel flag per event, gated interrupt
// - counts in wait, interrupt wakes cpu
// - register accesses ignored during wait
// - break halts the counter
// - break protects status unless clear enabled
// - armed clear survives break, completes later
// - prescaler select all ones picks external clock
// - external clock pin forced to input
// - each pin is capture or compare
// - channel flag read-then-write-zero clear
// - overflow flag read-then-write-zero clear
package tim_pkg;
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned DIV_W  = 6;

	// counter, modulo and divider values
	localparam logic [CNT_W-1:0] COUNT_RESET  = 16'h0000;
	localparam logic [CNT_W-1:0] COUNT_ONE    = 16'h0001;
	localparam logic [CNT_W-1:0] MODULO_RESET = 16'hFFFF;
	localparam logic [DIV_W-1:0] DIV_RESET    = 6'h00;
	localparam logic [DIV_W-1:0] DIV_ONE      = 6'h01;

	// prescaler select codes
	localparam logic [2:0] PS_EXT_CLOCK = 3'h7;

	// compare action / capture edge codes
	localparam logic [1:0] ACT_OFF    = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;

	// pair bookkeeping
	localparam int unsigned NUM_PAIRS = 2;

	// divider mask for the internal prescaler taps
	function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] ps);
		logic [DIV_W-1:0] m;
		m = DIV_RESET;
		case (ps)
			3'h0: m = 6'h00;
			3'h1: m = 6'h01;
			3'h2: m = 6'h03;
			3'h3: m = 6'h07;
			3'h4: m = 6'h0F;
			3'h5: m = 6'h1F;
			3'h6: m = 6'h3F;
			default: m = 6'h00;
		endcase
		return m;
	endfunction
endpackage

// file: hdl/timer_bus_if.sv
// shared timing and access signals between the timer modules
`timescale 1ns/1ps
`default_nettype none
interface timer_bus_if;
	logic tick;      // one counter step
	logic access_ok; // status clearing allowed

	modport presc (output tick);
	modport core  (input tick, output access_ok);
	modport flag  (input access_ok);
endinterface
`default_nettype wire

// file: hdl/tim_prescaler.sv
// counter clock prescaler with external clock selection
`timescale 1ns/1ps
`default_nettype none
module tim_prescaler
	import tim_pkg::*;
(
	input  wire logic       mclk_i,              // system clock
	input  wire logic       rstn_i,              // sync reset, low
	timer_bus_if.presc      bus,                 // tick out
	input  wire logic       run_i,               // counting allowed
	input  wire logic       clear_i,             // prescaler reset
	input  wire logic [2:0] prescaler_select_i,  // source select
	input  wire logic       external_timer_clock_i // external clock pin
);
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic             ext_prev;
		logic             tick;
	} presc_t;

	presc_t s;
	presc_t next_s;

	// divider taps or external rising edge
	always_comb begin
		next_s = s;
		next_s.ext_prev = external_timer_clock_i;
		next_s.tick = 1'b0;
		if (clear_i) begin
			next_s.div = DIV_RESET;
		end else if (run_i) begin
			if (prescaler_select_i == PS_EXT_CLOCK) begin
				next_s.tick = external_timer_clock_i & ~s.ext_prev;
			end else begin
				next_s.tick = (s.div & div_mask(prescaler_select_i))
					== div_mask(prescaler_select_i);
				next_s.div = s.div + DIV_ONE;
			end
		end
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign bus.tick = s.tick;
endmodule
`default_nettype wire

// file: hdl/tim_flag.sv
// sticky event flag with two-step read then write-zero clearing
`timescale 1ns/1ps
`default_nettype none
module tim_flag (
	input  wire logic mclk_i,  // system clock
	input  wire logic rstn_i,  // sync reset, low
	timer_bus_if.flag bus,     // access gating
	input  wire logic set_i,   // event pulse
	input  wire logic read_i,  // status register read
	input  wire logic clear_i, // write of zero to the flag
	output logic      flag_o   // flag state
);
	typedef struct packed {
		logic flag;
		logic armed;
	} flag_t;

	flag_t s;
	flag_t next_s;

	// set wins over clear; arming survives protected break
	always_comb begin
		next_s = s;
		if (set_i) begin
			next_s.flag = 1'b1;
			next_s.armed = 1'b0;
		end else if (bus.access_ok) begin
			if (clear_i && s.armed) begin
				next_s.flag = 1'b0;
				next_s.armed = 1'b0;
			end else if (read_i && s.flag) begin
				next_s.armed = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign flag_o = s.flag;
endmodule
`default_nettype wire

// file: test/tim_pin_model.sv
// far side model of the channel pins and the external clock pin
`timescale 1ns/1ps
`default_nettype none
module tim_pin_model (
	input  wire logic       mclk_i, // clock
	input  wire logic [3:0] drv_i,  // timer pin levels
	input  wire logic [3:0] oe_i,   // timer drives pin
	input  wire logic [3:0] lvl_i,  // far side levels
	input  wire logic       run_i,  // external clock on
	output logic [3:0]      pin_o,  // levels seen on pins
	output logic            eclk_o  // external clock
);
	logic [1:0] ph = 2'h0;

	// pin shows the timer where it drives, else the far side
	assign pin_o = (oe_i & drv_i) | (~oe_i & lvl_i);

	// clock of four cycles, standing low when not running
	always_ff @(posedge mclk_i) begin
		ph <= run_i ? ph + 2'h1 : 2'h0;
	end
	assign eclk_o = ph[1];
endmodule
`default_nettype wire

// file: test/tim_pwm_chk.sv
// port checker for the buffered pwm timer
`timescale 1ns/1ps
`default_nettype none
module tim_pwm_chk
	import tim_pkg::*;
(
	input wire logic              mclk_i,                // clock
	input wire logic              rstn_i,                // reset, low
	input wire logic              counter_reset_i,       // counter clear
	input wire logic [2:0]        prescaler_select_i,    // clock source
	input wire logic              overflow_irq_enable_i, // overflow gate
	input wire logic              ovf_clear_write_i,     // overflow clear
	input wire logic              pair01_link_i,         // link 0 and 1
	input wire logic              pair23_link_i,         // link 2 and 3
	input wire logic [NUM_CH-1:0] channel_irq_enable_i,  // channel gates
	input wire logic [NUM_CH-1:0] chan_clear_write_i,    // channel clears
	input wire logic              wait_mode_i,           // wait state
	input wire logic              break_i,               // break state
	input wire logic              port_direction_bit_i,  // ext pin dir
	input wire logic [NUM_CH-1:0] channel_pin_oe_o,      // pin drive
	input wire logic              ext_clock_pin_oe_o,    // ext pin drive
	input wire logic [CNT_W-1:0]  counter_o,             // counter
	input wire logic [1:0]        pair_active_odd_o,     // odd set active
	input wire logic              overflow_flag_o,       // overflow flag
	input wire logic [NUM_CH-1:0] channel_event_flag_o,  // channel flags
	input wire logic              irq_o                  // request
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	// ------------------------------------------------------------
	// flags, requests and counting
	// ------------------------------------------------------------
	ovf_at_wrap_a: assert property ($past(rstn_i) && !$past(counter_reset_i) &&
		$past(counter_o) != 16'h0000 && counter_o == 16'h0000 |-> overflow_flag_o)
		else $error("overflow flag missing at wrap");
	irq_raise_a: assert property (overflow_flag_o && overflow_irq_enable_i |=> irq_o)
		else $error("overflow request missing");
	irq_gate_a: assert property (irq_o |-> $past(overflow_flag_o && overflow_irq_enable_i) ||
		$past(|(channel_event_flag_o & channel_irq_enable_i)))
		else $error("request without enabled flag");
	ovf_clear_a: assert property ($past(rstn_i) && $fell(overflow_flag_o) |->
		$past(ovf_clear_write_i)) else $error("overflow flag fell without clear");
	chan_clear_a: assert property ($past(rstn_i) |-> ($past(channel_event_flag_o) &
		~channel_event_flag_o & ~$past(chan_clear_write_i)) == 4'h0)
		else $error("channel flag fell without clear");
	wait_hold_a: assert property (wait_mode_i |=> !$fell(overflow_flag_o) &&
		($past(channel_event_flag_o) & ~channel_event_flag_o) == 4'h0)
		else $error("flag cleared during wait");
	brk_halt_a: assert property ($past(rstn_i) && $past(break_i, 2) && $past(break_i) &&
		!$past(counter_reset_i) |-> $stable(counter_o)) else $error("counter moved in break");
	// ------------------------------------------------------------
	// pins and pairs
	// ------------------------------------------------------------
	odd_idle_a: assert property (!($past(pair01_link_i) && channel_pin_oe_o[1]) &&
		!($past(pair23_link_i) && channel_pin_oe_o[3])) else $error("linked odd pin driven");
	swap_wrap_a: assert property ($rose(pair_active_odd_o[0]) |->
		counter_o == 16'h0000 && pair01_link_i) else $error("pair swap off the wrap");
	ext_pin_a: assert property ($past(rstn_i) |-> ext_clock_pin_oe_o ==
		$past(port_direction_bit_i && prescaler_select_i != PS_EXT_CLOCK))
		else $error("external clock pin drive wrong");

	// main scenarios reached
	c_wrap: cover property (overflow_flag_o && irq_o);
	c_swap: cover property ($rose(pair_active_odd_o[0]));
	c_brk: cover property (break_i && overflow_flag_o);
endmodule
bind tim_pwm_top tim_pwm_chk u_chk (.*);
`default_nettype wire

// file: test/timer_buffered_pwm_channels_tb.sv
// self-checking bench for the buffered pwm timer
`timescale 1ns/1ps
`default_nettype none
module timer_buffered_pwm_channels_tb
	import tim_pkg::*;
;
	typedef struct {int ch; logic [1:0] act; logic tov; logic mx; int hi;} row_t;
	logic                          mclk_i = 0, rstn_i = 0, counter_stop_i = 1;
	logic                          counter_reset_i = 0, overflow_irq_enable_i = 0;
	logic                          ovf_status_read_i = 0, ovf_clear_write_i = 0;
	logic                          pair01_link_i = 0, pair23_link_i = 0, wait_mode_i = 0;
	logic                          break_i = 0, break_clear_enable_i = 0;
	logic                          port_direction_bit_i = 0, ext_run = 0;
	logic [2:0]                    prescaler_select_i = 3'h0;
	logic [CNT_W-1:0]              period_modulo_i = 16'h0013, seen;
	logic [NUM_CH-1:0]             unbuffered_mode_sel_i = '0, toggle_on_overflow_i = '0;
	logic [NUM_CH-1:0]             max_duty_force_i = '0, channel_irq_enable_i = '0;
	logic [NUM_CH-1:0]             compare_write_i = '0, chan_status_read_i = '0;
	logic [NUM_CH-1:0]             chan_clear_write_i = '0, pin_lvl = '0;
	logic [NUM_CH-1:0][1:0]        compare_action_sel_i = '0;
	logic [NUM_CH-1:0][CNT_W-1:0]  channel_compare_value_i = '0;
	wire logic [NUM_CH-1:0]        channel_pin_i;
	wire logic                     external_timer_clock_i;
	logic [NUM_CH-1:0]             channel_pin_o, channel_pin_oe_o, channel_event_flag_o;
	logic [NUM_CH-1:0][CNT_W-1:0]  channel_value_o;
	logic [CNT_W-1:0]              counter_o;
	logic [1:0]                    pair_active_odd_o;
	logic                          ext_clock_pin_oe_o, overflow_flag_o, irq_o;
	int                            fail_count = 0, cmp_count = 0, hi;
	row_t                          rows[5] = '{'{0, ACT_CLEAR, 1, 0, 8}, '{2, ACT_SET, 1, 0, 12},
		'{3, ACT_CLEAR, 0, 0, 0}, '{0, ACT_CLEAR, 0, 1, 20}, '{2, ACT_SET, 0, 1, 0}};

	tim_pwm_top u_dut (.*);
	tim_pin_model u_pins (.mclk_i, .drv_i(channel_pin_o), .oe_i(channel_pin_oe_o),
		.lvl_i(pin_lvl), .run_i(ext_run), .pin_o(channel_pin_i), .eclk_o(external_timer_clock_i));

	// clock of 25 ns
	always #12.5 mclk_i = ~mclk_i;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED at %0t seen %0h expected %0h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic wait_on(input logic wrap);
		int n;
		n = 0;
		tick(2);
		while ((wrap ? counter_o !== 16'h0000 : overflow_flag_o !== 1'b1) && n < 200) begin
			tick(1);
			n++;
		end
		if (n >= 200) begin
			fail_count++;
			conclude();
		end
	endtask
	task automatic clr_ovf(input logic rd);
		ovf_status_read_i = rd;
		tick(1);
		ovf_status_read_i = 0;
		ovf_clear_write_i = 1;
		tick(1);
		ovf_clear_write_i = 0;
		tick(1);
	endtask
	task automatic measure(input int c, input int e);
		hi = 0;
		repeat (20) begin
			tick(1);
			hi += channel_pin_o[c];
		end
		chk(hi, e);
	endtask
	// stop, clear, period, width, mode, toggle, action, start
	task automatic setup(input int c, input logic [1:0] a, input logic t, input logic m,
		input logic [15:0] v, input logic u);
		counter_stop_i = 1;
		counter_reset_i = 1;
		tick(1);
		counter_reset_i = 0;
		period_modulo_i = 16'h0013;
		compare_write_i[c] = 1;
		channel_compare_value_i[c] = v;
		tick(1);
		compare_write_i = '0;
		unbuffered_mode_sel_i[c] = u;
		toggle_on_overflow_i[c] = t;
		max_duty_force_i[c] = m;
		compare_action_sel_i[c] = a;
		counter_stop_i = 0;
		tick(40);
	endtask
	task automatic do_reset();
		rstn_i = 0;
		tick(2);
		chk({counter_o, 3'h0, overflow_flag_o, channel_pin_oe_o, 3'h0, irq_o}, 0);
		rstn_i = 1;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		do_reset();
		foreach (rows[i]) begin
			setup(rows[i].ch, rows[i].act, rows[i].tov, rows[i].mx, 16'h0007, 1);
			measure(rows[i].ch, rows[i].hi);
			chk(channel_pin_oe_o[rows[i].ch], 1);
		end
		$display("duty rows done");
		clr_ovf(1);
		overflow_irq_enable_i = 1;
		wait_on(0);
		tick(1);
		chk(irq_o, 1);
		clr_ovf(0);
		chk(overflow_flag_o, 1);
		ovf_status_read_i = 1;
		tick(1);
		ovf_status_read_i = 0;
		tick(20);
		clr_ovf(0);
		chk(overflow_flag_o, 1);
		clr_ovf(1);
		chk(overflow_flag_o, 0);
		overflow_irq_enable_i = 0;
		wait_on(0);
		tick(2);
		chk(irq_o, 0);
		$display("overflow test done");
		pair01_link_i = 1;
		compare_action_sel_i[1] = ACT_SET;
		unbuffered_mode_sel_i[1] = 1;
		setup(0, ACT_CLEAR, 1, 0, 16'h0005, 0);
		measure(0, 6);
		wait_on(1);
		compare_write_i[1] = 1;
		channel_compare_value_i[1] = 16'h000C;
		tick(1);
		compare_write_i = '0;
		tick(3);
		chk(channel_value_o[1], 16'h000C);
		chk(pair_active_odd_o[0], 0);
		wait_on(1);
		chk(pair_active_odd_o[0], 1);
		measure(0, 13);
		chk(channel_pin_oe_o[1:0], 2'h1);
		compare_write_i[0] = 1;
		tick(1);
		compare_write_i = '0;
		wait_on(1);
		chk(pair_active_odd_o[0], 0);
		pair23_link_i = 1;
		tick(3);
		chk(channel_pin_oe_o[3:2], 2'h1);
		$display("pair test done");
		clr_ovf(1);
		wait_on(0);
		ovf_status_read_i = 1;
		tick(1);
		ovf_status_read_i = 0;
		break_i = 1;
		tick(2);
		seen = counter_o;
		clr_ovf(1);
		chk(counter_o, seen);
		chk(overflow_flag_o, 1);
		break_i = 0;
		clr_ovf(0);
		chk(overflow_flag_o, 0);
		break_clear_enable_i = 1;
		wait_on(0);
		break_i = 1;
		clr_ovf(1);
		break_i = 0;
		tick(1);
		chk(overflow_flag_o, 0);
		$display("break test done");
		overflow_irq_enable_i = 1;
		wait_mode_i = 1;
		seen = counter_o;
		wait_on(0);
		tick(1);
		chk(counter_o === seen, 0);
		clr_ovf(1);
		chk({overflow_flag_o, irq_o}, 2'h3);
		wait_mode_i = 0;
		clr_ovf(1);
		chk(overflow_flag_o, 0);
		$display("wait test done");
		pair01_link_i = 0;
		compare_action_sel_i[1] = ACT_TOGGLE;
		unbuffered_mode_sel_i[1] = 0;
		channel_irq_enable_i[1] = 1;
		tick(3);
		pin_lvl[1] = 1;
		seen = counter_o;
		tick(4);
		chk(channel_value_o[1], seen);
		chk({channel_event_flag_o[1], irq_o, channel_pin_oe_o[1]}, 3'h6);
		chan_clear_write_i[1] = 1;
		tick(2);
		chk(channel_event_flag_o[1], 1);
		chan_clear_write_i[1] = 0;
		chan_status_read_i[1] = 1;
		tick(1);
		chan_status_read_i[1] = 0;
		chan_clear_write_i[1] = 1;
		tick(1);
		chan_clear_write_i[1] = 0;
		tick(1);
		chk(channel_event_flag_o[1], 0);
		$display("capture test done");
		period_modulo_i = 16'hFFFF;
		prescaler_select_i = PS_EXT_CLOCK;
		port_direction_bit_i = 1;
		counter_reset_i = 1;
		tick(1);
		counter_reset_i = 0;
		tick(3);
		chk({ext_clock_pin_oe_o, counter_o}, 0);
		ext_run = 1;
		tick(40);
		ext_run = 0;
		tick(6);
		chk(counter_o, 16'h000A);
		prescaler_select_i = 3'h0;
		tick(2);
		chk(ext_clock_pin_oe_o, 1);
		$display("external clock test done");
		do_reset();
		$display("reset test done");
		conclude();
	end
endmodule
`default_nettype wire
